/* File: atrmw_map.svh */
// constants for the indivisible read-modify-write bus sequencer
// assumes one 25 MHz clock; each bus state lasts one clock here (S2 and S9 repeat while waiting), ST_MOD lasts three
`ifndef ATRMW_MAP_SVH
`define ATRMW_MAP_SVH
`define ATRMW_CLK_PERIOD_NS 40
`define ATRMW_IDLE_STATES 2'h2
`define ATRMW_SYNC_WIDTH 35
`define ATRMW_ACK_LSB 0
`define ATRMW_BREQ_BIT 2
`define ATRMW_DATA_LSB 3
`define ATRMW_ADDR_RST 32'h00000000
`endif

/* File: atrmw_pkg.sv */
// types of the indivisible read-modify-write bus sequencer
// assumes atrmw_map.svh carries the numeric constants
package atrmw_pkg;
  typedef enum logic [3:0] {
    ST_IDLE = 4'h0, ST_S0 = 4'h1, ST_S1 = 4'h2, ST_S2 = 4'h3,
    ST_S3 = 4'h4, ST_S4 = 4'h5, ST_S5 = 4'h6, ST_MOD = 4'h7,
    ST_S6 = 4'h8, ST_S7 = 4'h9, ST_S8 = 4'hA, ST_S9 = 4'hB,
    ST_S10 = 4'hC, ST_S11 = 4'hD
  } atrmw_state_t;
  typedef enum logic [1:0] {
    OP_TEST_AND_SET_INSN = 2'h0,
    OP_COMPARE_SWAP = 2'h1,
    OP_DUAL_COMPARE_SWAP_INSN = 2'h2,
    OP_NONE = 2'h3
  } atrmw_op_t;
endpackage : atrmw_pkg

/* File: atrmw_sync.sv */
// two-flop synchroniser for the pin inputs of the sequencer
// assumes one clock, synchronous active-high reset, clock enable
`timescale 1ns/10ps
module atrmw_sync #(
  parameter int WIDTH = 1,
  parameter logic [WIDTH-1:0] RST_VAL = '0
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic ce,
  input wire logic [WIDTH-1:0] d,
  output logic [WIDTH-1:0] q
);
  logic [WIDTH-1:0] meta;
  always_ff @(posedge clk) begin
    if (rst) begin
      meta <= RST_VAL;
      q <= RST_VAL;
    end else if (ce) begin
      meta <= d;
      q <= meta;
    end
  end
endmodule : atrmw_sync

/* File: atrmw_seq.sv */
// indivisible read-modify-write bus sequencer, top module
// assumes acknowledges, bus request and read data arrive unsynchronised
// from pins; START and operand inputs come from logic on CLK
`timescale 1ns/10ps
`include "atrmw_map.svh"
module atrmw_seq (
  input wire logic CLK,
  input wire logic SYS_RST,
  input wire logic CE,
  input wire logic START,
  input wire logic [1:0] OP_KIND,
  input wire logic [1:0] READ_CYCLES,
  input wire logic [1:0] WRITE_CYCLES,
  input wire logic [31:0] READ_ADDR_IN,
  input wire logic [31:0] WRITE_ADDR_IN,
  input wire logic [2:0] FUNCTION_CODE_IN,
  input wire logic [1:0] SIZE_IN,
  input wire logic [31:0] WRITE_DATA_IN,
  input wire logic COMPARE_OK,
  input wire logic BUS_REQUEST_IN_N,
  input wire logic [1:0] PORT_SIZE_ACKNOWLEDGE_N,
  input wire logic [31:0] DATA_IN,
  output logic [31:0] ADDRESS,
  output logic [2:0] FUNCTION_CODE_LINES,
  output logic TRANSFER_SIZE_HI,
  output logic TRANSFER_SIZE_LO,
  output logic READ_NOT_WRITE,
  output logic EXTERNAL_CYCLE_START_N,
  output logic OPERAND_CYCLE_START_N,
  output logic ADDRESS_STROBE_N,
  output logic DATA_STROBE_N,
  output logic DATA_BUFFER_ENABLE_N,
  output logic INDIVISIBLE_CYCLE_FLAG_N,
  output logic BUS_GRANT_OUT_N,
  output logic [31:0] DATA_OUT,
  output logic DATA_OE,
  output logic [31:0] READ_DATA,
  output logic READ_VALID,
  output logic DONE,
  output logic BUSY
);
  // ==========================================================
  // pin synchronisers
  logic [`ATRMW_SYNC_WIDTH-1:0] sync_q;
  logic ack_seen, breq;
  logic [31:0] data_sync;
  atrmw_sync #(
    .WIDTH(`ATRMW_SYNC_WIDTH),
    .RST_VAL({32'h00000000, 3'h7})
  ) u_sync (
    .clk(CLK),
    .rst(SYS_RST),
    .ce(CE),
    .d({DATA_IN, BUS_REQUEST_IN_N, PORT_SIZE_ACKNOWLEDGE_N}),
    .q(sync_q)
  );
  // either acknowledge line low ends the cycle
  assign ack_seen = ~&sync_q[`ATRMW_ACK_LSB +: 2];
  assign breq = ~sync_q[`ATRMW_BREQ_BIT];
  assign data_sync = sync_q[`ATRMW_DATA_LSB +: 32];
  // ==========================================================
  // state and counters
  atrmw_pkg::atrmw_state_t state, next_state;
  atrmw_pkg::atrmw_op_t op, next_op;
  logic [1:0] rd_left, next_rd_left;
  logic [1:0] wr_left, next_wr_left;
  logic [1:0] idle_cnt, next_idle_cnt;
  logic [31:0] wr_addr, next_wr_addr;
  logic accept;
  // test-and-set always writes; compare-swaps only on a match
  function automatic logic write_needed(input atrmw_pkg::atrmw_op_t k,
                                        input logic cmp);
    write_needed = (k == atrmw_pkg::OP_TEST_AND_SET_INSN) || cmp;
  endfunction : write_needed
  function automatic logic in_span(input atrmw_pkg::atrmw_state_t s,
                                   input atrmw_pkg::atrmw_state_t lo,
                                   input atrmw_pkg::atrmw_state_t hi);
    in_span = (s >= lo) && (s <= hi);
  endfunction : in_span
  // a start is refused while the bus is granted away
  assign accept = (state == atrmw_pkg::ST_IDLE) && START && BUS_GRANT_OUT_N
    && (atrmw_pkg::atrmw_op_t'(OP_KIND) != atrmw_pkg::OP_NONE);
  always_comb begin
    next_state = state;
    next_op = op;
    next_rd_left = rd_left;
    next_wr_left = wr_left;
    next_idle_cnt = idle_cnt;
    next_wr_addr = wr_addr;
    case (state)
      atrmw_pkg::ST_IDLE: begin
        if (accept) begin
          next_state = atrmw_pkg::ST_S0;
          next_op = atrmw_pkg::atrmw_op_t'(OP_KIND);
          next_rd_left = READ_CYCLES;
          next_wr_left = WRITE_CYCLES;
          next_wr_addr = WRITE_ADDR_IN;
        end
      end
      atrmw_pkg::ST_S0: next_state = atrmw_pkg::ST_S1;
      atrmw_pkg::ST_S1: next_state = atrmw_pkg::ST_S2;
      atrmw_pkg::ST_S2: begin
        // no acknowledge: stay, one wait state per clock
        if (ack_seen) begin
          next_state = atrmw_pkg::ST_S3;
        end
      end
      atrmw_pkg::ST_S3: next_state = atrmw_pkg::ST_S4;
      atrmw_pkg::ST_S4: next_state = atrmw_pkg::ST_S5;
      atrmw_pkg::ST_S5: begin
        if (rd_left != 2'h0) begin
          next_rd_left = rd_left - 2'h1;
          next_state = atrmw_pkg::ST_S0;
        end else begin
          next_idle_cnt = `ATRMW_IDLE_STATES;
          next_state = atrmw_pkg::ST_MOD;
        end
      end
      atrmw_pkg::ST_MOD: begin
        if (idle_cnt != 2'h0) begin
          next_idle_cnt = idle_cnt - 2'h1;
        end else if (write_needed(op, COMPARE_OK)) begin
          next_state = atrmw_pkg::ST_S6;
        end else begin
          next_state = atrmw_pkg::ST_IDLE;
        end
      end
      atrmw_pkg::ST_S6: next_state = atrmw_pkg::ST_S7;
      atrmw_pkg::ST_S7: next_state = atrmw_pkg::ST_S8;
      atrmw_pkg::ST_S8: next_state = atrmw_pkg::ST_S9;
      atrmw_pkg::ST_S9: begin
        if (ack_seen) begin
          next_state = atrmw_pkg::ST_S10;
        end
      end
      atrmw_pkg::ST_S10: next_state = atrmw_pkg::ST_S11;
      atrmw_pkg::ST_S11: begin
        if (wr_left != 2'h0) begin
          next_wr_left = wr_left - 2'h1;
          next_state = atrmw_pkg::ST_S6;
        end else begin
          next_state = atrmw_pkg::ST_IDLE;
        end
      end
      default: next_state = atrmw_pkg::ST_IDLE;
    endcase
  end

  always_ff @(posedge CLK) begin
    if (SYS_RST) begin
      state <= atrmw_pkg::ST_IDLE;
      op <= atrmw_pkg::OP_NONE;
      rd_left <= 2'h0;
      wr_left <= 2'h0;
      idle_cnt <= 2'h0;
      wr_addr <= `ATRMW_ADDR_RST;
    end else if (CE) begin
      state <= next_state;
      op <= next_op;
      rd_left <= next_rd_left;
      wr_left <= next_wr_left;
      idle_cnt <= next_idle_cnt;
      wr_addr <= next_wr_addr;
    end
  end

  // ==========================================================
  // bus outputs, decoded from the next state so every pin is a flop
  logic [31:0] next_address, next_data_out, next_read_data;
  logic [2:0] next_fc;
  logic [1:0] next_size;
  logic next_rw, next_ecs_n, next_as_n, next_ds_n, next_data_buffer_enable_n;
  logic next_flag_n, next_grant_n, next_oe, next_read_valid, next_done;
  atrmw_pkg::atrmw_state_t ns;

  always_comb begin
    ns = next_state;
    next_address = ADDRESS;
    next_fc = FUNCTION_CODE_LINES;
    next_size = {TRANSFER_SIZE_HI, TRANSFER_SIZE_LO};
    next_data_out = DATA_OUT;
    next_read_data = READ_DATA;
    next_read_valid = 1'b0;
    next_done = 1'b0;
    if (accept) begin
      next_address = READ_ADDR_IN;
      next_fc = FUNCTION_CODE_IN;
      next_size = SIZE_IN;
    end
    // the write address may differ from the read address
    if (ns == atrmw_pkg::ST_S6) begin
      next_address = wr_addr;
      next_data_out = WRITE_DATA_IN;
    end
    if (state == atrmw_pkg::ST_S4) begin
      next_read_data = data_sync;
      next_read_valid = 1'b1;
    end
    if (state != atrmw_pkg::ST_IDLE && ns == atrmw_pkg::ST_IDLE) begin
      next_done = 1'b1;
    end
    next_ecs_n = !(ns == atrmw_pkg::ST_S0 ||
      ns == atrmw_pkg::ST_S6);
    next_as_n = !(in_span(ns, atrmw_pkg::ST_S1, atrmw_pkg::ST_S4) ||
      in_span(ns, atrmw_pkg::ST_S7, atrmw_pkg::ST_S10));
    next_ds_n = !(in_span(ns, atrmw_pkg::ST_S1, atrmw_pkg::ST_S4) ||
                  in_span(ns, atrmw_pkg::ST_S9, atrmw_pkg::ST_S10));
    // buffer enable stays on through S11 so the write data holds
    next_data_buffer_enable_n = !(in_span(ns, atrmw_pkg::ST_S2, atrmw_pkg::ST_S4) ||
                    in_span(ns, atrmw_pkg::ST_S7, atrmw_pkg::ST_S11));
    next_rw = !in_span(ns, atrmw_pkg::ST_S6, atrmw_pkg::ST_S11);
    next_oe = in_span(ns, atrmw_pkg::ST_S8, atrmw_pkg::ST_S11);
    next_flag_n = (ns == atrmw_pkg::ST_IDLE);
    // request waits until the sequence is over and the flag is off
    next_grant_n = !(breq && state == atrmw_pkg::ST_IDLE && !accept
                     && INDIVISIBLE_CYCLE_FLAG_N);
  end

  always_ff @(posedge CLK) begin
    if (SYS_RST) begin
      ADDRESS <= `ATRMW_ADDR_RST;
      FUNCTION_CODE_LINES <= 3'h0;
      TRANSFER_SIZE_HI <= 1'b0;
      TRANSFER_SIZE_LO <= 1'b0;
      READ_NOT_WRITE <= 1'b1;
      EXTERNAL_CYCLE_START_N <= 1'b1;
      OPERAND_CYCLE_START_N <= 1'b1;
      ADDRESS_STROBE_N <= 1'b1;
      DATA_STROBE_N <= 1'b1;
      DATA_BUFFER_ENABLE_N <= 1'b1;
      INDIVISIBLE_CYCLE_FLAG_N <= 1'b1;
      BUS_GRANT_OUT_N <= 1'b1;
      DATA_OUT <= 32'h00000000;
      DATA_OE <= 1'b0;
      READ_DATA <= 32'h00000000;
      READ_VALID <= 1'b0;
      DONE <= 1'b0;
      BUSY <= 1'b0;
    end else if (CE) begin
      ADDRESS <= next_address;
      FUNCTION_CODE_LINES <= next_fc;
      TRANSFER_SIZE_HI <= next_size[1];
      TRANSFER_SIZE_LO <= next_size[0];
      READ_NOT_WRITE <= next_rw;
      EXTERNAL_CYCLE_START_N <= next_ecs_n;
      OPERAND_CYCLE_START_N <= next_ecs_n;
      ADDRESS_STROBE_N <= next_as_n;
      DATA_STROBE_N <= next_ds_n;
      DATA_BUFFER_ENABLE_N <= next_data_buffer_enable_n;
      INDIVISIBLE_CYCLE_FLAG_N <= next_flag_n;
      BUS_GRANT_OUT_N <= next_grant_n;
      DATA_OUT <= next_data_out;
      DATA_OE <= next_oe;
      READ_DATA <= next_read_data;
      READ_VALID <= next_read_valid;
      DONE <= next_done;
      BUSY <= !next_flag_n;
    end
  end

  // ==========================================================
  // checks
  flag_cover_a: assert property (@(posedge CLK) disable iff (SYS_RST)
    (state != atrmw_pkg::ST_IDLE) |-> !INDIVISIBLE_CYCLE_FLAG_N)
    else $error("indivisible flag dropped mid sequence");
  no_grant_a: assert property (@(posedge CLK) disable iff (SYS_RST)
    !INDIVISIBLE_CYCLE_FLAG_N |-> BUS_GRANT_OUT_N)
    else $error("grant given during indivisible sequence");
  s0_start_a: assert property (@(posedge CLK) disable iff (SYS_RST)
    (state == atrmw_pkg::ST_S0) |-> !EXTERNAL_CYCLE_START_N
      && !OPERAND_CYCLE_START_N && READ_NOT_WRITE && ADDRESS_STROBE_N)
    else $error("S0 signals wrong");
  s1_strobe_a: assert property (@(posedge CLK) disable iff (SYS_RST)
    (state == atrmw_pkg::ST_S1) |-> !ADDRESS_STROBE_N && !DATA_STROBE_N
      && EXTERNAL_CYCLE_START_N && DATA_BUFFER_ENABLE_N)
    else $error("S1 strobes wrong");
  read_wait_a: assert property (@(posedge CLK) disable iff (SYS_RST)
    (state == atrmw_pkg::ST_S2) && CE && !ack_seen
      |=> (state == atrmw_pkg::ST_S2) && !DATA_BUFFER_ENABLE_N)
    else $error("read left S2 without acknowledge");
  read_capture_a: assert property (@(posedge CLK)
    disable iff (SYS_RST) (state == atrmw_pkg::ST_S4) && CE
      |=> READ_VALID && (READ_DATA == $past(data_sync)))
    else $error("read data not captured at S4");
  data_drive_a: assert property (@(posedge CLK) disable iff (SYS_RST)
    DATA_OE |-> in_span(state, atrmw_pkg::ST_S8, atrmw_pkg::ST_S11)
      && !READ_NOT_WRITE)
    else $error("data bus driven outside S8 to S11");
  skip_write_a: assert property (@(posedge CLK) disable iff (SYS_RST)
    (state == atrmw_pkg::ST_MOD) && CE && (idle_cnt == 2'h0)
      && !write_needed(op, COMPARE_OK) |=> (state == atrmw_pkg::ST_IDLE)
      && INDIVISIBLE_CYCLE_FLAG_N)
    else $error("failed compare still wrote");
  s11_release_a: assert property (@(posedge CLK)
    disable iff (SYS_RST) (state == atrmw_pkg::ST_S11) |-> ADDRESS_STROBE_N
      && DATA_STROBE_N && DATA_OE && !READ_NOT_WRITE)
    else $error("S11 outputs wrong");
endmodule : atrmw_seq

/* File: atrmw_mem_model.sv */
// behavioural memory that answers the indivisible sequencer on its bus
// assumes a 32-bit port; acks after wait_cycles falling clock edges with both strobes low
`timescale 1ns/10ps
module atrmw_mem_model (
  input wire logic clk,
  input wire logic [31:0] address,
  input wire logic read_not_write,
  input wire logic address_strobe_n,
  input wire logic data_strobe_n,
  input wire logic [31:0] data_out,
  input wire logic [31:0] read_value,
  input wire logic [3:0] wait_cycles,
  output logic [1:0] ack_n,
  output logic [31:0] data_in,
  output logic [31:0] stored_data,
  output logic [31:0] stored_addr
);
  // ==========================================================
  // responder
  logic [3:0] count;
  initial begin
    ack_n = 2'h3;
    data_in = 32'h0;
    count = 4'h0;
    stored_data = 32'h0;
    stored_addr = 32'h0;
  end
  always @(negedge clk) begin
    if (!address_strobe_n && !data_strobe_n) begin
      if (count < wait_cycles) begin
        count <= count + 4'h1;
        ack_n <= 2'h3;
      end else begin
        ack_n <= 2'h0;
      end
      if (read_not_write) begin
        data_in <= read_value;
      end else begin
        stored_data <= data_out;
        stored_addr <= address;
      end
    end else begin
      // released lanes toggle so a stale value is never mistaken for data
      count <= 4'h0;
      ack_n <= 2'h3;
      data_in <= ~data_in;
    end
  end
endmodule : atrmw_mem_model

/* File: atrmw_tb.sv */
// self-checking bench for the indivisible read-modify-write sequencer
// assumes atrmw_mem_model answers on the far side of the bus
`timescale 1ns/10ps
module tb_top;
  logic clk = 1'b0, rst = 1'b1, start = 1'b0, ok = 1'b0, req_n = 1'b1;
  logic [1:0] kind = 2'h0, rc = 2'h0, wc = 2'h0, ack_n;
  logic [3:0] wt = 4'h0;
  logic [31:0] raddr = 32'h0, waddr = 32'h0, wdata = 32'h0, rval = 32'h0;
  logic [31:0] din, st_data, st_addr, address, dout, rdata, rd_addr;
  logic rw, ecs_n, as_n, ds_n, data_buffer_enable_n, flag_n, grant_n, oe, vld, done;
  logic ocs_n, busy;
  logic [2:0] fc;
  logic [1:0] sz;
  logic ack_seen = 1'b0, as_prev = 1'b1;
  int rd_n, wr_n, vld_n, bad_n, mismatches = 0, checks_done = 0;
  always #20 clk = ~clk;
  atrmw_seq u_atrmw_seq (.CLK(clk), .SYS_RST(rst), .CE(1'b1),
    .START(start), .OP_KIND(kind), .READ_CYCLES(rc), .WRITE_CYCLES(wc),
    .READ_ADDR_IN(raddr), .WRITE_ADDR_IN(waddr), .FUNCTION_CODE_IN(3'h5),
    .SIZE_IN(2'h1), .WRITE_DATA_IN(wdata), .COMPARE_OK(ok),
    .BUS_REQUEST_IN_N(req_n), .PORT_SIZE_ACKNOWLEDGE_N(ack_n),
    .DATA_IN(din), .ADDRESS(address), .FUNCTION_CODE_LINES(fc),
    .TRANSFER_SIZE_HI(sz[1]), .TRANSFER_SIZE_LO(sz[0]),
    .READ_NOT_WRITE(rw),
    .EXTERNAL_CYCLE_START_N(ecs_n), .OPERAND_CYCLE_START_N(ocs_n),
    .ADDRESS_STROBE_N(as_n), .DATA_STROBE_N(ds_n),
    .DATA_BUFFER_ENABLE_N(data_buffer_enable_n), .INDIVISIBLE_CYCLE_FLAG_N(flag_n),
    .BUS_GRANT_OUT_N(grant_n), .DATA_OUT(dout), .DATA_OE(oe),
    .READ_DATA(rdata), .READ_VALID(vld), .DONE(done), .BUSY(busy));
  atrmw_mem_model u_atrmw_mem_model (.clk(clk), .address(address),
    .read_not_write(rw), .address_strobe_n(as_n), .data_strobe_n(ds_n),
    .data_out(dout), .read_value(rval), .wait_cycles(wt), .ack_n(ack_n),
    .data_in(din), .stored_data(st_data), .stored_addr(st_addr));
  // ==========================================================
  // bus monitor, sampled where outputs have settled
  always @(negedge clk) begin
    if (!ecs_n && rw) begin
      rd_n++;
      rd_addr = address;
    end
    if (!ecs_n && !rw) wr_n++;
    if (vld) vld_n++;
    if (!flag_n && !grant_n) bad_n++;
    if (flag_n && (!as_n || !ecs_n)) bad_n++;
    if (oe && rw) bad_n++;
    // codes and size stand from S0 until the flag drops
    if (!flag_n && (fc != 3'h5 || sz != 2'h1)) bad_n++;
    if (ocs_n != ecs_n || busy != !flag_n) bad_n++;
    if (!ecs_n && !as_n) bad_n++;
    if (!as_n && !rw && data_buffer_enable_n) bad_n++;
    if (as_n && rw && !data_buffer_enable_n) bad_n++;
    // a strobe that ends before any acknowledge means waits were skipped
    if (as_n && !as_prev && !ack_seen) bad_n++;
    if (as_n && !as_prev) ack_seen = 1'b0;
    // a stale acknowledge seen after the strobe rose must not count
    if (!as_n && ack_n != 2'h3) ack_seen = 1'b1;
    as_prev = as_n;
  end
  // ==========================================================
  // shared tasks
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      mismatches++;
      $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check
  task automatic run_op(input logic [1:0] k, input logic [1:0] r,
      input logic [1:0] w, input logic c, input logic [3:0] t,
      input int nw, input logic rq);
    int i;
    int nr;
    logic seen;
    nr = (k == 2'h3) ? 0 : int'(r) + 1;
    seen = 1'b0;
    @(negedge clk);
    kind = k;
    rc = r;
    wc = w;
    ok = c;
    wt = t;
    raddr = 32'h00001000 + 32'(t);
    waddr = 32'h00002004 + 32'(t);
    wdata = 32'hA5C30000 + 32'(t);
    rval = 32'h5A960000 + 32'(t);
    rd_n = 0;
    wr_n = 0;
    vld_n = 0;
    bad_n = 0;
    req_n = rq;
    start = 1'b1;
    @(negedge clk);
    start = 1'b0;
    for (i = 0; i < 300 && !seen; i++) begin
      @(negedge clk);
      seen = done;
    end
    check(32'(seen), 32'(k != 2'h3));
    check(32'(rd_n), 32'(nr));
    check(32'(vld_n), 32'(nr));
    check(32'(wr_n), 32'(nw));
    check(32'(bad_n), 32'h0);
    if (nr > 0) begin
      check(rd_addr, raddr);
      check(rdata, rval);
    end
    if (nw > 0) begin
      check(st_data, wdata);
      check(st_addr, waddr);
    end
  endtask : run_op
  // ==========================================================
  // scenarios
  task automatic t_tas;
    run_op(atrmw_pkg::OP_TEST_AND_SET_INSN, 2'h0, 2'h0, 1'b0, 4'h0, 1, 1'b1);
  endtask : t_tas
  task automatic t_cas_fail;
    run_op(atrmw_pkg::OP_COMPARE_SWAP, 2'h0, 2'h0, 1'b0, 4'h1, 0, 1'b1);
  endtask : t_cas_fail
  task automatic t_cas_ok;
    run_op(atrmw_pkg::OP_COMPARE_SWAP, 2'h0, 2'h0, 1'b1, 4'h2, 1, 1'b1);
  endtask : t_cas_ok
  task automatic t_dual_compare_swap_insn_wait;
    run_op(atrmw_pkg::OP_DUAL_COMPARE_SWAP_INSN, 2'h1, 2'h1, 1'b1, 4'h4, 2,
      1'b1);
  endtask : t_dual_compare_swap_insn_wait
  task automatic t_none;
    run_op(atrmw_pkg::OP_NONE, 2'h0, 2'h0, 1'b1, 4'h0, 0, 1'b1);
  endtask : t_none
  task automatic t_grant;
    int i;
    logic g;
    run_op(atrmw_pkg::OP_TEST_AND_SET_INSN, 2'h0, 2'h0, 1'b0, 4'h1, 1, 1'b0);
    g = 1'b0;
    for (i = 0; i < 8 && !g; i++) begin
      @(negedge clk);
      g = !grant_n;
    end
    check(32'(g), 32'h1);
    start = 1'b1;
    @(negedge clk);
    start = 1'b0;
    repeat (4) @(negedge clk);
    check(32'(flag_n), 32'h1);
    req_n = 1'b1;
    for (i = 0; i < 8 && g; i++) begin
      @(negedge clk);
      g = !grant_n;
    end
    check(32'(g), 32'h0);
  endtask : t_grant
  // ==========================================================
  // run control
  task automatic end_sim;
    $display("checks_done=%0d mismatches=%0d", checks_done, mismatches);
    if (mismatches == 0 && checks_done > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask : end_sim
  initial begin
    // six sequences; the OP_NONE one idles 300 cycles, the rest far less
    #(40 * 4000);
    mismatches++;
    end_sim();
  end
  initial begin
    repeat (12) @(posedge clk);
    @(negedge clk);
    rst = 1'b0;
    repeat (3) @(negedge clk);
    t_tas();
    t_cas_fail();
    t_cas_ok();
    t_dual_compare_swap_insn_wait();
    t_none();
    t_grant();
    end_sim();
  end
endmodule : tb_top
